// ### logic/ccrlc_top.sv
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ccrlc_top
	import ccrlc_pkg::*;
#(
	parameter int KEEPALIVE_COUNT = KEEPALIVE_CYCLES,
	parameter logic [25:0] HOTPLUG_TERMINAL = HOTPLUG_LAST
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [AXIL_AW-1:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	// AXI4-Lite read
	input wire logic [AXIL_AW-1:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	// Transceiver and peer pins, asynchronous
	input wire logic init_clk_in,
	input wire logic transceiver_init_in,
	input wire logic clock_unlocked_in,
	input wire logic channel_ready_in,
	input wire logic peer_ready_in,
	// Transceiver control outputs
	output logic transceiver_init_out,
	output logic interconnect_only_reset,
	output logic keepalive_pulse_out,
	// Link and reset outputs
	output logic link_status_output,
	output logic link_error_irq,
	output logic lite_reset_n,
	output logic sys_reset_n_out,
	output logic txn_enable,
	output logic user_clock_route_sel
);

	ccrlc_pins_t pins_raw;
	ccrlc_pins_t pins;
	ccrlc_cfg_t cfg_reg;
	ccrlc_state_t state_reg;
	ccrlc_state_t state_next;
	logic init_clk_prev_reg;
	logic init_edge;
	logic phy_ok;
	logic peer_lost;
	logic do_write;
	logic [KEEPALIVE_W-1:0] ka_cnt_reg;
	logic [HOTPLUG_W-1:0] hp_cnt_reg;
	logic hp_hold_reg;
	logic linked_next;
	logic [AXIL_AW-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic wstrb0_reg;

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	assign pins_raw = '{peer_ready: peer_ready_in, chan_ready: channel_ready_in,
		clk_unlocked: clock_unlocked_in, init_in: transceiver_init_in,
		init_clk: init_clk_in};

	ccrlc_sync #(
		.WIDTH($bits(ccrlc_pins_t))
	) u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(pins_raw),
		.sync_out(pins)
	);

	// Rising edge of the free-running init clock
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			init_clk_prev_reg <= 1'b0;
		else
			init_clk_prev_reg <= pins.init_clk;
	end
	assign init_edge = pins.init_clk && !init_clk_prev_reg;

	// ----------------------------------------
	// Link detect state machine
	// ----------------------------------------
	// Serial PHY needs lock and channel ready before link-up
	assign phy_ok = !cfg_reg.phy_serial || (!pins.clk_unlocked && pins.chan_ready);
	// Far end dropped out of reset or readiness while linked
	assign peer_lost = (state_reg == ST_LINKED) && !pins.peer_ready;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (cfg_reg.link_enable && !link_error_irq)
					state_next = ST_WAIT_PHY;
			ST_WAIT_PHY:
				if (phy_ok)
					state_next = ST_WAIT_PEER;
			ST_WAIT_PEER:
				if (!phy_ok)
					state_next = ST_WAIT_PHY;
				else if (pins.peer_ready)
					state_next = ST_LINKED;
			ST_LINKED:
				if (!cfg_reg.link_enable || !phy_ok || !pins.peer_ready)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
		// Init input resets the interconnect, so the link falls
		if (pins.init_in)
			state_next = ST_IDLE;
	end
	assign linked_next = (state_next == ST_LINKED);

	// Local reset returns to idle and relinks after release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// ----------------------------------------
	// Link status, error and reset outputs
	// ----------------------------------------
	// Status follows the linked state only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			link_status_output <= 1'b0;
		else
			link_status_output <= linked_next;
	end

	// Sticky error on master when the slave end resets; clears by reset only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			link_error_irq <= 1'b0;
		else if (cfg_reg.role_master && peer_lost)
			link_error_irq <= 1'b1;
	end

	// Lite port (own clock outside) held in reset until link up
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lite_reset_n <= 1'b0;
		else
			lite_reset_n <= linked_next;
	end

	// Common clock slave hands link status out as system reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sys_reset_n_out <= 1'b0;
		else if (cfg_reg.common_clock && !cfg_reg.role_master)
			sys_reset_n_out <= linked_next;
		else
			sys_reset_n_out <= 1'b1;
	end

	// Master may issue only when both ends are up
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			txn_enable <= 1'b0;
		else
			txn_enable <= cfg_reg.role_master && linked_next && pins.peer_ready;
	end

	// User clock routed out only for a common clock slave
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			user_clock_route_sel <= 1'b0;
		else
			user_clock_route_sel <= cfg_reg.common_clock && !cfg_reg.role_master;
	end

	// ----------------------------------------
	// Keepalive and hot-plug counters
	// ----------------------------------------
	// Keepalive counter cleared while down, one pulse per period
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !linked_next)
		begin
			ka_cnt_reg <= '0;
			keepalive_pulse_out <= 1'b0;
		end
		else if (init_edge && ka_cnt_reg == KEEPALIVE_W'(KEEPALIVE_COUNT - 1))
		begin
			ka_cnt_reg <= '0;
			keepalive_pulse_out <= 1'b1;
		end
		else
		begin
			if (init_edge)
				ka_cnt_reg <= ka_cnt_reg + 1'b1;
			keepalive_pulse_out <= 1'b0;
		end
	end

	// Hot-plug counter runs while the link is down
	always_ff @(posedge aclk)
	begin
		if (!aresetn || linked_next)
			hp_cnt_reg <= '0;
		else if (init_edge)
			hp_cnt_reg <= (hp_cnt_reg == HOTPLUG_TERMINAL) ? '0 : hp_cnt_reg + 1'b1;
	end

	// Overflow holds init out for one init clock period
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			hp_hold_reg <= 1'b0;
		else if (init_edge)
			hp_hold_reg <= !linked_next && (hp_cnt_reg == HOTPLUG_TERMINAL);
	end

	// Init output from init input plus overflow
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			transceiver_init_out <= 1'b0;
		else
			transceiver_init_out <= pins.init_in || hp_hold_reg;
	end

	// Interconnect reset on local reset or init input
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			interconnect_only_reset <= 1'b1;
		else
			interconnect_only_reset <= pins.init_in;
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign do_write = !s_axil_awready && !s_axil_wready && !s_axil_bvalid;

	// Write channels: address and data taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axil_awready <= 1'b1;
			s_axil_wready <= 1'b1;
			s_axil_bvalid <= 1'b0;
			s_axil_bresp <= RESP_OKAY;
		end
		else
		begin
			if (s_axil_awvalid && s_axil_awready)
				s_axil_awready <= 1'b0;
			if (s_axil_wvalid && s_axil_wready)
				s_axil_wready <= 1'b0;
			if (do_write)
			begin
				s_axil_bvalid <= 1'b1;
				s_axil_bresp <= (awaddr_reg == CTRL_OFFSET) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axil_bvalid && s_axil_bready)
			begin
				s_axil_bvalid <= 1'b0;
				s_axil_awready <= 1'b1;
				s_axil_wready <= 1'b1;
			end
		end
	end

	// Capture write payloads
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb0_reg <= 1'b0;
		end
		else
		begin
			if (s_axil_awvalid && s_axil_awready)
				awaddr_reg <= {s_axil_awaddr[AXIL_AW-1:2], 2'h0};
			if (s_axil_wvalid && s_axil_wready)
			begin
				wdata_reg <= s_axil_wdata;
				wstrb0_reg <= s_axil_wstrb[0];
			end
		end
	end

	// Control register; master role forces independent clock
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cfg_reg <= ccrlc_cfg_t'(CTRL_RESET);
		else if (do_write && awaddr_reg == CTRL_OFFSET && wstrb0_reg)
		begin
			cfg_reg <= ccrlc_cfg_t'(wdata_reg[CTRL_WIDTH-1:0]);
			if (wdata_reg[CTRL_ROLE_MASTER_BIT])
				cfg_reg.common_clock <= 1'b0;
		end
	end

	// Read channel: decode at address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axil_arready <= 1'b1;
			s_axil_rvalid <= 1'b0;
			s_axil_rdata <= '0;
			s_axil_rresp <= RESP_OKAY;
		end
		else if (s_axil_arvalid && s_axil_arready)
		begin
			s_axil_arready <= 1'b0;
			s_axil_rvalid <= 1'b1;
			s_axil_rresp <= RESP_OKAY;
			if (s_axil_araddr[AXIL_AW-1:2] == CTRL_OFFSET[AXIL_AW-1:2])
				s_axil_rdata <= {28'h0, cfg_reg};
			else if (s_axil_araddr[AXIL_AW-1:2] == STATUS_OFFSET[AXIL_AW-1:2])
				s_axil_rdata <= {22'h0, state_reg, 1'b0, link_error_irq,
					link_status_output, pins};
			else if (s_axil_araddr[AXIL_AW-1:2] == HOTPLUG_OFFSET[AXIL_AW-1:2])
				s_axil_rdata <= {6'h0, hp_cnt_reg};
			else if (s_axil_araddr[AXIL_AW-1:2] == KEEPALIVE_OFFSET[AXIL_AW-1:2])
				s_axil_rdata <= {18'h0, ka_cnt_reg};
			else
			begin
				s_axil_rdata <= '0;
				s_axil_rresp <= RESP_SLVERR;
			end
		end
		else if (s_axil_rvalid && s_axil_rready)
		begin
			s_axil_rvalid <= 1'b0;
			s_axil_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	link_state_a: assert property (@(posedge aclk) disable iff (!aresetn)
		link_status_output |-> state_reg == ST_LINKED)
		else $error("link status high outside linked state");

	phy_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == ST_WAIT_PHY && cfg_reg.phy_serial
		&& (pins.clk_unlocked || !pins.chan_ready)) |=> state_reg != ST_WAIT_PEER)
		else $error("link-up advanced without transceiver ready");

	keepalive_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		keepalive_pulse_out |-> $past(ka_cnt_reg) == KEEPALIVE_W'(KEEPALIVE_COUNT - 1)
		##1 !keepalive_pulse_out)
		else $error("keepalive pulse at wrong count or too long");

	keepalive_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!link_status_output |-> ka_cnt_reg == '0 && !keepalive_pulse_out)
		else $error("keepalive counter running while link down");

	link_error_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(cfg_reg.role_master && peer_lost) |=> link_error_irq && !link_status_output
		##1 link_error_irq)
		else $error("slave loss not reported on master");

	iconn_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pins.init_in |=> interconnect_only_reset && transceiver_init_out)
		else $error("init input did not assert interconnect reset");

	axi_reset_a: assert property (@(posedge aclk)
		!aresetn |=> interconnect_only_reset && !link_status_output)
		else $error("local reset did not assert interconnect reset");

	hotplug_ovf_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(init_edge && hp_cnt_reg == HOTPLUG_TERMINAL && !linked_next && !pins.init_in)
		|=> ##1 transceiver_init_out)
		else $error("hot-plug overflow did not assert init output");

	lite_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		lite_reset_n == link_status_output)
		else $error("lite port released apart from link status");

	txn_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		txn_enable |-> link_status_output && $past(pins.peer_ready))
		else $error("transactions enabled with an end not ready");

	master_clock_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_reg.role_master |-> !cfg_reg.common_clock ##1 !user_clock_route_sel)
		else $error("master side in common clock mode");

endmodule : ccrlc_top

// ### include/ccrlc_pkg.sv
package ccrlc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int AXIL_AW = 8;
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] HOTPLUG_OFFSET = 8'h08;
	localparam logic [7:0] KEEPALIVE_OFFSET = 8'h0c;

	// CTRL field positions
	localparam int CTRL_ROLE_MASTER_BIT = 0;
	localparam int CTRL_COMMON_CLOCK_BIT = 1;
	localparam int CTRL_PHY_SERIAL_BIT = 2;
	localparam int CTRL_LINK_ENABLE_BIT = 3;
	localparam int CTRL_WIDTH = 4;
	// Slave role, independent clock, parallel PHY, link enabled
	localparam logic [3:0] CTRL_RESET = 4'h8;

	// STATUS field positions
	localparam int STAT_PINS_LSB = 0;
	localparam int STAT_LINK_BIT = 5;
	localparam int STAT_ERROR_BIT = 6;
	localparam int STAT_STATE_LSB = 8;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Timing counts in init clock edges, counter widths, synchroniser depth in aclk stages
	// ----------------------------------------
	localparam int KEEPALIVE_CYCLES = 10000;
	localparam int KEEPALIVE_W = 14;
	localparam int HOTPLUG_W = 26;
	localparam logic [25:0] HOTPLUG_LAST = 26'h3ffffff;
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic link_enable;
		logic phy_serial;
		logic common_clock;
		logic role_master;
	} ccrlc_cfg_t;

	typedef struct packed {
		logic peer_ready;
		logic chan_ready;
		logic clk_unlocked;
		logic init_in;
		logic init_clk;
	} ccrlc_pins_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_PHY,
		ST_WAIT_PEER,
		ST_LINKED
	} ccrlc_state_t;

endpackage : ccrlc_pkg

// ### logic/ccrlc_sync.sv
`timescale 1ns/1ps
module ccrlc_sync
	import ccrlc_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// ----------------------------------------
	// Two flip-flop level synchroniser
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : ccrlc_sync

// ### bench/ccrlc_far_model.sv
`timescale 1ns/1ps
module ccrlc_far_model
	import ccrlc_pkg::*;
(
	// Bench controls
	input wire logic aresetn,
	input wire logic lock_ok,
	input wire logic chan_up,
	input wire logic peer_up,
	// From the bridge
	input wire logic transceiver_init_out,
	// To the bridge
	output logic init_clk_in,
	output logic clock_unlocked_in,
	output logic channel_ready_in,
	output logic peer_ready_in
);
	// ----------------------------------------
	// Transceiver core and peer end
	// ----------------------------------------
	// Free-running init clock, ten aclk periods, running from time zero
	initial
	begin
		init_clk_in = 1'b0;
		#1;
		forever #20 init_clk_in = ~init_clk_in;
	end
	// Deskew reference clock, 200 MHz, supplied by the system side
	logic deskew_ref_clk;
	initial
	begin
		deskew_ref_clk = 1'b0;
		forever #2.5 deskew_ref_clk = ~deskew_ref_clk;
	end
	// Core init restarts the user clock source and drops the channel
	assign clock_unlocked_in = !lock_ok || transceiver_init_out;
	assign channel_ready_in = chan_up && !transceiver_init_out;
	// Peer end is reset together with the local end
	assign peer_ready_in = peer_up && aresetn;
endmodule : ccrlc_far_model

// ### bench/test_c2c_clock_reset_link_established_state_control.sv
`timescale 1ns/1ps
module test_c2c_clock_reset_link_established_state_control
	import ccrlc_pkg::*;
	;
	localparam int KA = 5;
	localparam int INIT_PER = 10;
	logic aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
	logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
	logic s_axil_rready, transceiver_init_in, clock_unlocked_in, channel_ready_in;
	logic [AXIL_AW-1:0] s_axil_awaddr, s_axil_araddr;
	logic [31:0] s_axil_wdata, s_axil_rdata, rd;
	logic [3:0] s_axil_wstrb;
	logic [1:0] s_axil_bresp, s_axil_rresp, resp;
	logic init_clk_in, peer_ready_in, transceiver_init_out, interconnect_only_reset;
	logic keepalive_pulse_out, link_status_output, link_error_irq, lite_reset_n;
	logic sys_reset_n_out, txn_enable, user_clock_route_sel, lock_ok, chan_up, peer_up;
	int miscompares, checks, n;

	// Bridge under test and its far side
	ccrlc_top #(.KEEPALIVE_COUNT(KA), .HOTPLUG_TERMINAL(26'h7)) DUT (.*);
	ccrlc_far_model FAR (.*);

	// ----------------------------------------
	// Common tasks
	// ----------------------------------------
	// Clock, 4 ns
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Verdict and end of run
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// Reset for six cycles
	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		check(interconnect_only_reset, 1);
		check(link_status_output, 0);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : do_reset

	// Bounded wait for a link status level
	task automatic wait_link(input logic v);
		for (n = 0; n < 300 && link_status_output !== v; n++)
			@(posedge aclk);
		check(link_status_output, v);
	endtask : wait_link

	// Register write
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axil_awaddr <= a;
		s_axil_wdata <= d;
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axil_awvalid && s_axil_awready)
				s_axil_awvalid <= 1'b0;
			if (s_axil_wvalid && s_axil_wready)
				s_axil_wvalid <= 1'b0;
		end
		while (!s_axil_bvalid);
		r = s_axil_bresp;
		s_axil_bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_write

	// Register read
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axil_arvalid && s_axil_arready)
				s_axil_arvalid <= 1'b0;
		end
		while (!s_axil_rvalid);
		d = s_axil_rdata;
		r = s_axil_rresp;
		s_axil_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_read

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Register reset value, unmapped and read-only places, master forces split clocks
	task automatic t_regs;
		peer_up <= 1'b0;
		do_reset();
		axi_read(CTRL_OFFSET, rd, resp);
		check(rd, 32'(CTRL_RESET));
		axi_read(8'h10, rd, resp);
		check(resp, RESP_SLVERR);
		axi_write(STATUS_OFFSET, 32'h0, resp);
		check(resp, RESP_SLVERR);
		axi_write(CTRL_OFFSET, 32'hb, resp);
		check(resp, RESP_OKAY);
		axi_read(CTRL_OFFSET, rd, resp);
		check(rd, 32'h9);
	endtask : t_regs

	// Parallel slave link-up, keepalive spacing, link drop
	task automatic t_parallel;
		do_reset();
		lock_ok <= 1'b0;
		peer_up <= 1'b1;
		wait_link(1);
		check(lite_reset_n, 1);
		check(user_clock_route_sel, 0);
		axi_read(STATUS_OFFSET, rd, resp);
		check(rd[STAT_STATE_LSB+1:STAT_LINK_BIT], 5'h19);
		for (n = 0; n < 300 && keepalive_pulse_out !== 1'b1; n++)
			@(posedge aclk);
		@(posedge aclk);
		for (n = 1; n < 300 && keepalive_pulse_out !== 1'b1; n++)
			@(posedge aclk);
		check(n, KA * INIT_PER);
		peer_up <= 1'b0;
		wait_link(0);
		check(lite_reset_n, 0);
		check(link_error_irq, 0);
	endtask : t_parallel

	// Serial link waits for lock, falls when channel ready drops
	task automatic t_serial;
		do_reset();
		axi_write(CTRL_OFFSET, 32'hc, resp);
		lock_ok <= 1'b0;
		chan_up <= 1'b1;
		peer_up <= 1'b1;
		repeat (40) @(posedge aclk);
		check(link_status_output, 0);
		lock_ok <= 1'b1;
		wait_link(1);
		chan_up <= 1'b0;
		wait_link(0);
	endtask : t_serial

	// Common clock slave drives system reset from link and routes user clock
	task automatic t_common;
		peer_up <= 1'b0;
		do_reset();
		axi_write(CTRL_OFFSET, 32'ha, resp);
		repeat (3) @(posedge aclk);
		check(user_clock_route_sel, 1);
		check(sys_reset_n_out, 0);
		peer_up <= 1'b1;
		wait_link(1);
		check(sys_reset_n_out, 1);
		axi_write(CTRL_OFFSET, 32'hb, resp);
		repeat (3) @(posedge aclk);
		check(user_clock_route_sel, 0);
	endtask : t_common

	// Master sees slave reset, error sticks until local reset
	task automatic t_master_loss;
		do_reset();
		axi_write(CTRL_OFFSET, 32'h9, resp);
		wait_link(1);
		check(txn_enable, 1);
		peer_up <= 1'b0;
		wait_link(0);
		repeat (2) @(posedge aclk);
		check(link_error_irq, 1);
		check(txn_enable, 0);
		peer_up <= 1'b1;
		repeat (40) @(posedge aclk);
		check(link_status_output, 0);
		do_reset();
		check(link_error_irq, 0);
		axi_write(CTRL_OFFSET, 32'h9, resp);
		wait_link(1);
	endtask : t_master_loss

	// Init input forces interconnect reset and init output
	task automatic t_init_in;
		do_reset();
		wait_link(1);
		transceiver_init_in <= 1'b1;
		for (n = 0; n < 20 && interconnect_only_reset !== 1'b1; n++)
			@(posedge aclk);
		check(interconnect_only_reset, 1);
		for (n = 0; n < 20 && transceiver_init_out !== 1'b1; n++)
			@(posedge aclk);
		check(transceiver_init_out, 1);
		wait_link(0);
		transceiver_init_in <= 1'b0;
		wait_link(1);
	endtask : t_init_in

	// Hot-plug counter wraps while link down, clears at link-up
	task automatic t_hotplug;
		peer_up <= 1'b0;
		do_reset();
		for (n = 0; n < 300 && transceiver_init_out !== 1'b1; n++)
			@(posedge aclk);
		check(n >= 60 && n < 150, 1);
		peer_up <= 1'b1;
		wait_link(1);
		axi_read(HOTPLUG_OFFSET, rd, resp);
		check(rd, 0);
	endtask : t_hotplug

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	// Inputs at time zero, then the scenarios
	initial
	begin
		miscompares = 0;
		checks = 0;
		aresetn = 1'b0;
		{s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
		{s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
		s_axil_wstrb = 4'hf;
		{transceiver_init_in, lock_ok, chan_up, peer_up} = '0;
		t_regs();
		t_parallel();
		t_serial();
		t_common();
		t_master_loss();
		t_init_in();
		t_hotplug();
		conclude();
	end

	// Hang guard, far beyond the expected run
	initial
	begin
		#200000;
		miscompares++;
		conclude();
	end
endmodule : test_c2c_clock_reset_link_established_state_control
